// file: cfi_cfg.svh
`ifndef CFI_CFG_SVH
`define CFI_CFG_SVH

// clock and pulse timing
`define CFI_CLK_MHZ        40
`define CFI_PULSE_US       128
`define CFI_PULSE_CYCLES   (`CFI_PCNT_W'(`CFI_PULSE_US * `CFI_CLK_MHZ))
`define CFI_PCNT_W         13

// event sources, one bit each
`define CFI_NSRC           12
`define CFI_B_CV           0
`define CFI_B_DONE         1
`define CFI_B_ICAP         2
`define CFI_B_PPATH        3
`define CFI_B_VLOOP        4
`define CFI_B_THERM        5
`define CFI_B_VALID        6
`define CFI_B_OVP          7
`define CFI_B_OCP          8
`define CFI_B_UVLO         9
`define CFI_B_COLD         10
`define CFI_B_CHILLY       11

// register byte offsets
`define CFI_ADDR_W         8
`define CFI_A_FLAG         8'h00
`define CFI_A_MASK         8'h04
`define CFI_A_CTRL         8'h08
`define CFI_A_LIVE         8'h0C
`define CFI_A_IRQ_STAT     8'h10
`define CFI_A_IRQ_MASK     8'h14

// control register fields
`define CFI_CTRL_RAIL_LO   0
`define CFI_CTRL_RAIL_HI   1
`define CFI_CTRL_TDOUBLE   2
`define CFI_CTRL_CHG_EN    3
`define CFI_CTRL_W         4
`define CFI_CTRL_RST       4'h8

// live status fields above the source bits
`define CFI_LIVE_READY     12
`define CFI_LIVE_SFAULT    13
`define CFI_LIVE_CHG       14
`define CFI_LIVE_PULSE     15

// interrupt status bits
`define CFI_IRQ_W          3
`define CFI_IRQ_PULSE      0
`define CFI_IRQ_SFAULT     1
`define CFI_IRQ_OVFL       2

// pulse queue
`define CFI_PEND_W         4
`define CFI_PEND_MAX       4'hF
`define CFI_PEND_ONE       4'h1

// system rail source settings
`define CFI_RAIL_AUTO      2'h0
`define CFI_RAIL_BAT       2'h1
`define CFI_RAIL_FLOAT     2'h2
`define CFI_RAIL_PULLDN    2'h3

`endif

// file: cfi_pkg.sv
package cfi_pkg;
  typedef enum logic {
    CFI_PS_IDLE,
    CFI_PS_LOW
  } cfi_pulse_state_t;
endpackage : cfi_pkg

// file: cfi_pulse_gen.sv
`timescale 1ns/1ps
`include "cfi_cfg.svh"
// fixed-width low pulse timer on the internal clock
module cfi_pulse_gen #(
  parameter logic [`CFI_PCNT_W-1:0] PULSE_CYCLES = `CFI_PULSE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      busy_o
);
  cfi_pkg::cfi_pulse_state_t state_r;
  logic [`CFI_PCNT_W-1:0]    cnt_r;
  logic                      last_w;

  assign last_w = (cnt_r == PULSE_CYCLES - 1'b1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= cfi_pkg::CFI_PS_IDLE;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        cfi_pkg::CFI_PS_IDLE: begin
          cnt_r <= '0;
          if (start_i) begin
            state_r <= cfi_pkg::CFI_PS_LOW;
          end
        end
        cfi_pkg::CFI_PS_LOW: begin
          cnt_r <= cnt_r + 1'b1; // see [RULE16]
          if (last_w) begin
            state_r <= cfi_pkg::CFI_PS_IDLE;
          end
        end
        default: state_r <= cfi_pkg::CFI_PS_IDLE;
      endcase
    end
  end

  assign busy_o = (state_r == cfi_pkg::CFI_PS_LOW);
endmodule : cfi_pulse_gen

// file: cfi_fault_irq.sv
`timescale 1ns/1ps
`include "cfi_cfg.svh"
// Contract
// [RULE1] interrupt line is open-drain and silent unless start-up ended valid
// [RULE2] line idles released and is pulled low exactly 128 us per event
// [RULE3] every flag-setting event, charge done included, gives one pulse (code: an event arriving with 15 pulses queued gives none)
// [RULE4] each source has a host mask; masked events give no pulse
// [RULE5] unmasking a standing condition gives no pulse; only new edges count
// [RULE6] constant-voltage entry sets its flag; charging and timer unchanged
// [RULE7] charge done pauses charging, resets timer; resume on toggle or recharge
// [RULE8] regulation loops set flags, cut current, optionally double the timer
// [RULE9] input-valid flag on both edges, resets timer, gates charging
// [RULE10] input overvoltage pauses charging, resets timer, rail from battery
// [RULE11] battery overcurrent on battery only disables charge, disconnects battery
// [RULE12] cold pauses charging and pauses the safety timer
// [RULE13] chilly keeps charging at reduced current, optionally doubles timer
// [RULE14] flags hold until read; a source re-arms only after its flag clears
// [RULE15] default rail setting: input when valid, else battery
// [RULE16] pulse width from a clock counter; coincident events are queued (code: events in one cycle share one pulse)
// [RULE17] host pulls the line up, sees the pulse, reads flags to clear
module cfi_fault_irq #(
  parameter logic [`CFI_PCNT_W-1:0] PULSE_CYCLES = `CFI_PULSE_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [31:0]           adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // condition pins from the analog side
  input  wire logic [`CFI_NSRC-1:0]  cond_i,
  input  wire logic                  recharge_threshold_i,
  input  wire logic                  startup_done_i,
  input  wire logic                  startup_fault_i,
  // open-drain interrupt pin, and the level irq from irq status
  output logic                       int_o,
  output logic                       int_oe_o,
  output logic                       irq_o,
  // charger and rail controls
  output logic                       charge_enable_o,
  output logic                       reduced_current_o,
  output logic                       safety_timer_reset_o,
  output logic                       safety_timer_pause_o,
  output logic                       safety_timer_double_o,
  output logic                       rail_from_input_o,
  output logic                       rail_from_battery_o,
  output logic                       rail_pulldown_o,
  output logic                       battery_disconnect_o
);
  localparam int N = `CFI_NSRC;

  // two-flop synchronisers for every condition pin
  localparam int NS = N + 3;
  logic [NS-1:0] pin_w;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;
  assign pin_w = {startup_fault_i, startup_done_i, recharge_threshold_i, cond_i};

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= pin_w[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  logic [N-1:0] cond_w;
  logic         rch_w;
  logic         sdone_w;
  logic         sfault_w;
  assign cond_w   = sync2_r[N-1:0];
  assign rch_w    = sync2_r[N];
  assign sdone_w  = sync2_r[N+1];
  assign sfault_w = sync2_r[N+2];

  // registers
  logic [N-1:0]            flag_r;
  logic [N-1:0]            mask_r;
  logic [`CFI_CTRL_W-1:0]  ctrl_r;
  logic [`CFI_IRQ_W-1:0]   irq_stat_r;
  logic [`CFI_IRQ_W-1:0]   irq_mask_r;
  logic [N-1:0]            prev_r;
  logic                    ready_r;
  logic                    sfault_r;
  logic                    done_pause_r;
  logic [`CFI_PEND_W-1:0]  pend_r;
  logic                    start_r;
  logic                    ack_r;
  logic [31:0]             rdat_r;

  // bus decode
  logic [`CFI_ADDR_W-1:0] a_w;
  logic                   req_w;
  logic                   wr_w;
  logic                   rd_w;
  logic [31:0]            wmask_w;
  logic [31:0]            wval_w;
  logic                   hit_flag_w;
  logic                   hit_mask_w;
  logic                   hit_ctrl_w;
  logic                   hit_live_w;
  logic                   hit_istat_w;
  logic                   hit_imask_w;
  assign a_w         = adr_i[`CFI_ADDR_W-1:0];
  assign req_w       = cyc_i & stb_i;
  assign wr_w        = req_w & we_i & ack_r;
  assign rd_w        = req_w & ~we_i & ack_r;
  assign wmask_w     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wval_w      = dat_i & wmask_w;
  assign hit_flag_w  = (adr_i[31:`CFI_ADDR_W] == '0) && (a_w == `CFI_A_FLAG);
  assign hit_mask_w  = (adr_i[31:`CFI_ADDR_W] == '0) && (a_w == `CFI_A_MASK);
  assign hit_ctrl_w  = (adr_i[31:`CFI_ADDR_W] == '0) && (a_w == `CFI_A_CTRL);
  assign hit_live_w  = (adr_i[31:`CFI_ADDR_W] == '0) && (a_w == `CFI_A_LIVE);
  assign hit_istat_w = (adr_i[31:`CFI_ADDR_W] == '0) && (a_w == `CFI_A_IRQ_STAT);
  assign hit_imask_w = (adr_i[31:`CFI_ADDR_W] == '0) && (a_w == `CFI_A_IRQ_MASK);

  // event detection, only after a valid start-up
  logic [N-1:0] rise_w;
  logic [N-1:0] edge_w;
  logic [N-1:0] trig_w;
  logic [N-1:0] flag_clr_w;
  logic [N-1:0] flag_nxt;
  assign rise_w = cond_w & ~prev_r;
  // input validity reports both directions
  assign edge_w = ready_r ? ((rise_w & ~(N'(1) << `CFI_B_VALID))
                             | ((cond_w ^ prev_r) & (N'(1) << `CFI_B_VALID)))
                          : '0; // see [RULE1] see [RULE9] see [RULE5]
  assign trig_w = edge_w & ~mask_r & ~flag_r; // see [RULE4] see [RULE14] see [RULE3]
  assign flag_clr_w = (hit_flag_w & rd_w) ? {N{1'b1}}
                    : (hit_flag_w & wr_w) ? wval_w[N-1:0] : '0;
  assign flag_nxt = (flag_r & ~flag_clr_w) | edge_w; // see [RULE14]

  // pulse queue
  logic                   busy_w;
  logic                   start_w;
  logic                   add_w;
  logic                   full_w;
  logic [`CFI_PEND_W-1:0] pend_nxt;
  assign add_w    = |trig_w;
  assign full_w   = (pend_r == `CFI_PEND_MAX);
  // wait until the pin itself is released so queued pulses keep two idle cycles
  assign start_w  = (pend_r != '0) & ~busy_w & ~start_r & ~int_oe_o; // see [RULE16]
  assign pend_nxt = pend_r + ((add_w & ~full_w) ? `CFI_PEND_ONE : '0)
                    - (start_w ? `CFI_PEND_ONE : '0); // see [RULE16]

  // charger response
  logic vin_w;
  logic ovp_w;
  logic ocp_w;
  logic uvlo_w;
  logic chg_toggle_w;
  logic resume_w;
  logic chg_en_w;
  logic loop_w;
  logic tmr_reset_w;
  logic [1:0] rail_w;
  logic rail_in_w;
  logic rail_bat_w;
  assign vin_w   = cond_w[`CFI_B_VALID];
  assign ovp_w   = cond_w[`CFI_B_OVP];
  assign uvlo_w  = cond_w[`CFI_B_UVLO];
  assign ocp_w   = cond_w[`CFI_B_OCP] & ~vin_w; // see [RULE11]
  assign chg_toggle_w = hit_ctrl_w & wr_w & sel_i[0]
                        & (dat_i[`CFI_CTRL_CHG_EN] != ctrl_r[`CFI_CTRL_CHG_EN]);
  assign resume_w = (vin_w != prev_r[`CFI_B_VALID]) | chg_toggle_w | rch_w; // see [RULE7]
  assign chg_en_w = ready_r & ctrl_r[`CFI_CTRL_CHG_EN] & vin_w & ~ovp_w & ~ocp_w
                    & ~cond_w[`CFI_B_COLD] & ~done_pause_r
                    & (rail_w == `CFI_RAIL_AUTO); // see [RULE9] see [RULE10] see [RULE12]
  assign loop_w = cond_w[`CFI_B_ICAP] | cond_w[`CFI_B_PPATH] | cond_w[`CFI_B_VLOOP]
                  | cond_w[`CFI_B_THERM]; // see [RULE8]
  assign tmr_reset_w = ready_r & (rise_w[`CFI_B_DONE] | rise_w[`CFI_B_OVP]
                       | (vin_w != prev_r[`CFI_B_VALID])); // see [RULE7] see [RULE9] see [RULE10]
  // battery setting falls back to automatic below the undervoltage level
  assign rail_w = ((ctrl_r[`CFI_CTRL_RAIL_HI:`CFI_CTRL_RAIL_LO] == `CFI_RAIL_BAT) & uvlo_w)
                  ? `CFI_RAIL_AUTO : ctrl_r[`CFI_CTRL_RAIL_HI:`CFI_CTRL_RAIL_LO];
  assign rail_in_w  = (rail_w == `CFI_RAIL_AUTO) & vin_w & ~ovp_w; // see [RULE15] see [RULE10]
  assign rail_bat_w = ((rail_w == `CFI_RAIL_AUTO) & ~rail_in_w) | (rail_w == `CFI_RAIL_BAT);

  // read mux
  logic [31:0] live_w;
  logic [31:0] rmux_w;
  assign live_w = {16'h0000, busy_w, charge_enable_o, sfault_r, ready_r, cond_w};
  assign rmux_w = hit_flag_w  ? {{(32-N){1'b0}}, flag_r}
                : hit_mask_w  ? {{(32-N){1'b0}}, mask_r}
                : hit_ctrl_w  ? {{(32-`CFI_CTRL_W){1'b0}}, ctrl_r}
                : hit_live_w  ? live_w
                : hit_istat_w ? {{(32-`CFI_IRQ_W){1'b0}}, irq_stat_r}
                : hit_imask_w ? {{(32-`CFI_IRQ_W){1'b0}}, irq_mask_r}
                : 32'h0000_0000;

  // irq status: set wins over write-one clear
  logic [`CFI_IRQ_W-1:0] irq_set_w;
  logic [`CFI_IRQ_W-1:0] irq_clr_w;
  logic                  sfault_set_w;
  assign sfault_set_w = sdone_w & sfault_w & ~ready_r & ~sfault_r;
  assign irq_set_w = {add_w & full_w, sfault_set_w, start_w};
  assign irq_clr_w = (hit_istat_w & wr_w) ? wval_w[`CFI_IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= req_w & ~ack_r;
      rdat_r <= (req_w & ~ack_r & ~we_i) ? rmux_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r     <= '0;
      ctrl_r     <= `CFI_CTRL_RST;
      irq_mask_r <= '0;
    end else begin
      if (hit_mask_w & wr_w) begin
        mask_r <= (mask_r & ~wmask_w[N-1:0]) | wval_w[N-1:0]; // see [RULE4]
      end
      if (hit_ctrl_w & wr_w) begin
        ctrl_r <= (ctrl_r & ~wmask_w[`CFI_CTRL_W-1:0]) | wval_w[`CFI_CTRL_W-1:0];
      end
      if (hit_imask_w & wr_w) begin
        irq_mask_r <= (irq_mask_r & ~wmask_w[`CFI_IRQ_W-1:0]) | wval_w[`CFI_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r       <= '0;
      prev_r       <= '0;
      ready_r      <= 1'b0;
      sfault_r     <= 1'b0;
      done_pause_r <= 1'b0;
      pend_r       <= '0;
      start_r      <= 1'b0;
      irq_stat_r   <= '0;
    end else begin
      // before release prev follows the pins so nothing standing counts as new
      prev_r     <= cond_w; // see [RULE9]
      flag_r     <= flag_nxt;
      pend_r     <= pend_nxt;
      start_r    <= start_w;
      irq_stat_r <= (irq_stat_r & ~irq_clr_w) | irq_set_w;
      if (sdone_w & ~sfault_w & ~sfault_r) begin
        ready_r <= 1'b1; // see [RULE1]
      end
      if (sfault_set_w) begin
        sfault_r <= 1'b1; // see [RULE1]
      end
      if (ready_r & rise_w[`CFI_B_DONE]) begin
        done_pause_r <= 1'b1; // see [RULE7]
      end else if (resume_w) begin
        done_pause_r <= 1'b0;
      end
    end
  end

  cfi_pulse_gen #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pulse (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (start_w),
    .busy_o  (busy_w)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_oe_o              <= 1'b0;
      irq_o                 <= 1'b0;
      charge_enable_o       <= 1'b0;
      reduced_current_o     <= 1'b0;
      safety_timer_reset_o  <= 1'b0;
      safety_timer_pause_o  <= 1'b0;
      safety_timer_double_o <= 1'b0;
      rail_from_input_o     <= 1'b0;
      rail_from_battery_o   <= 1'b0;
      rail_pulldown_o       <= 1'b0;
      battery_disconnect_o  <= 1'b0;
    end else begin
      int_oe_o              <= busy_w; // see [RULE2] see [RULE16]
      irq_o                 <= |(irq_stat_r & ~irq_mask_r);
      charge_enable_o       <= chg_en_w; // see [RULE6]
      reduced_current_o     <= loop_w | cond_w[`CFI_B_CHILLY]; // see [RULE8] see [RULE13]
      safety_timer_reset_o  <= tmr_reset_w;
      safety_timer_pause_o  <= cond_w[`CFI_B_COLD]; // see [RULE12]
      safety_timer_double_o <= ctrl_r[`CFI_CTRL_TDOUBLE]
                               & (loop_w | cond_w[`CFI_B_CHILLY]); // see [RULE8] see [RULE13]
      rail_from_input_o     <= rail_in_w; // see [RULE15]
      rail_from_battery_o   <= rail_bat_w & ~ocp_w; // see [RULE10] see [RULE11]
      rail_pulldown_o       <= (rail_w == `CFI_RAIL_PULLDN);
      battery_disconnect_o  <= ocp_w; // see [RULE11]
    end
  end

  // the pin itself only ever drives low
  assign int_o = 1'b0; // see [RULE2]
  assign dat_o = rdat_r;
  assign ack_o = ack_r;
endmodule : cfi_fault_irq

// file: cfi_fault_irq_properties.sv
`timescale 1ns/1ps
`include "cfi_cfg.svh"
module cfi_fault_irq_properties #(
  parameter logic [`CFI_PCNT_W-1:0] PULSE_CYCLES = `CFI_PULSE_CYCLES
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        startup_done_i,
  input wire logic        startup_fault_i,
  input wire logic        int_o,
  input wire logic        int_oe_o,
  input wire logic        charge_enable_o,
  input wire logic        safety_timer_reset_o,
  input wire logic        rail_from_input_o,
  input wire logic        rail_from_battery_o,
  input wire logic        battery_disconnect_o
);
  logic [13:0] hi_cnt_r;
  logic        ok_r;
  logic        bad_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // length of the current low drive, and whether start-up was seen good
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_cnt_r <= 14'h0000;
      ok_r     <= 1'b0;
      bad_r    <= 1'b0;
    end else begin
      hi_cnt_r <= int_oe_o ? hi_cnt_r + 14'h0001 : 14'h0000;
      ok_r     <= ok_r | (startup_done_i & ~startup_fault_i & ~bad_r);
      bad_r    <= bad_r | (startup_done_i & startup_fault_i & ~ok_r);
    end
  end
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  a_data_pin_low: assert property (int_o == 1'b0)
    else $error("interrupt pin data not low");
  a_quiet_unready: assert property (!ok_r |-> !int_oe_o)
    else $error("interrupt pulse before valid start-up");
  a_pulse_exact: assert property ($fell(int_oe_o) |-> hi_cnt_r == PULSE_CYCLES)
    else $error("interrupt pulse width wrong");
  a_pulse_bounded: assert property (int_oe_o |-> hi_cnt_r < PULSE_CYCLES)
    else $error("interrupt pulse too long");
  a_pulse_gap: assert property ($fell(int_oe_o) |-> !int_oe_o [*2])
    else $error("queued pulses too close");
  a_wb_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not one wait state");
  a_wb_idle_data: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_timer_pulse: assert property (safety_timer_reset_o |=> !safety_timer_reset_o)
    else $error("timer reset not a single pulse");
  a_rail_single: assert property (!(rail_from_input_o && rail_from_battery_o))
    else $error("rail fed from both sources");
  a_ocp_isolate: assert property (battery_disconnect_o |->
    !rail_from_battery_o && !charge_enable_o)
    else $error("battery not isolated on overcurrent");
endmodule : cfi_fault_irq_properties
bind cfi_fault_irq cfi_fault_irq_properties #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
  .clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .startup_done_i, .startup_fault_i, .int_o,
  .int_oe_o, .charge_enable_o, .safety_timer_reset_o, .rail_from_input_o, .rail_from_battery_o,
  .battery_disconnect_o
);

// file: cfi_host_monitor.sv
`timescale 1ns/1ps
// host end of the interrupt line: pull-up and low pulse meter
module cfi_host_monitor (
  input  wire logic        clk_i,
  input  wire logic        int_i,
  input  wire logic        int_oe_i,
  output logic             pin_o,
  output logic [7:0]       pulse_cnt_o,
  output logic [15:0]      width_o
);
  logic [15:0] run_r = 16'h0000;
  initial pulse_cnt_o = 8'h00;
  initial width_o = 16'h0000;
  assign pin_o = int_oe_i ? int_i : 1'b1;
  always @(posedge clk_i) begin
    if (pin_o === 1'b0) begin
      run_r <= run_r + 16'h0001;
    end else if (run_r != 16'h0000) begin
      pulse_cnt_o <= pulse_cnt_o + 8'h01;
      width_o     <= run_r;
      run_r       <= 16'h0000;
    end
  end
endmodule : cfi_host_monitor

// file: charger_fault_interrupt_unit_bench.sv
`timescale 1ns/1ps
`include "cfi_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module charger_fault_interrupt_unit_bench;
  localparam logic [`CFI_PCNT_W-1:0] P = 13'h0008;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0] adr_i = 32'h0000_0000, dat_i = 32'h0000_0000, dat_o, q;
  logic [3:0]  sel_i = 4'hF;
  logic [11:0] cond_i = 12'h000;
  logic recharge_threshold_i = 1'b0, startup_done_i = 1'b0, startup_fault_i = 1'b0;
  logic ack_o, int_o, int_oe_o, irq_o, charge_enable_o, reduced_current_o, pin;
  logic safety_timer_reset_o, safety_timer_pause_o, safety_timer_double_o, rail_from_input_o;
  logic rail_from_battery_o, rail_pulldown_o, battery_disconnect_o;
  logic [7:0]  pcnt, exp_p = 8'h00;
  logic [15:0] pwid;
  int n_tests = 0, n_mismatch = 0, n_cyc = 0, n_trst = 0, n0;
  always #12.5 clk_i = ~clk_i;
  cfi_fault_irq #(.PULSE_CYCLES(P)) uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .cond_i, .recharge_threshold_i, .startup_done_i,
    .startup_fault_i, .int_o, .int_oe_o, .irq_o, .charge_enable_o, .reduced_current_o,
    .safety_timer_reset_o, .safety_timer_pause_o, .safety_timer_double_o, .rail_from_input_o,
    .rail_from_battery_o, .rail_pulldown_o, .battery_disconnect_o);
  cfi_host_monitor host (.clk_i, .int_i(int_o), .int_oe_i(int_oe_o), .pin_o(pin),
    .pulse_cnt_o(pcnt), .width_o(pwid));
  task automatic close_out();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  always @(posedge clk_i) begin
    n_cyc++;
    if (safety_timer_reset_o === 1'b1) n_trst++;
    if (n_cyc > 10000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {24'h00_0000, a};
    dat_i <= d;
    // ack is judged as sampled at a rising edge; only the bench timeout ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask : chk_rd
  task automatic pin_set(input int b, input logic v);
    @(posedge clk_i);
    cond_i[b] <= v;
    repeat (20) @(posedge clk_i);
  endtask : pin_set
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask : settle
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rd(`CFI_A_MASK, 32'h0000_0000);
    chk_rd(`CFI_A_CTRL, 32'h0000_0008);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk_rd(8'h40, 32'h0000_0000);
    pin_set(0, 1'b1);
    `CHK(pcnt, 8'h00)
    chk_rd(`CFI_A_FLAG, 32'h0000_0000);
    pin_set(0, 1'b0);
    startup_done_i <= 1'b1;
    settle();
    for (int b = 0; b < 12; b++) begin
      pin_set(b, 1'b1);
      exp_p++;
      `CHK(pcnt, exp_p)
      `CHK(pwid, {3'h0, P})
      chk_rd(`CFI_A_FLAG, 32'h0000_0001 << b);
      pin_set(b, 1'b0);
      if (b == 6) begin
        exp_p++;
        chk_rd(`CFI_A_FLAG, 32'h0000_0040);
      end
      `CHK(pcnt, exp_p)
    end
    wb(1'b1, `CFI_A_MASK, 32'h0000_0003);
    pin_set(0, 1'b1);
    pin_set(1, 1'b1);
    `CHK(pcnt, exp_p)
    chk_rd(`CFI_A_FLAG, 32'h0000_0003);
    wb(1'b1, `CFI_A_MASK, 32'h0000_0000);
    repeat (20) @(posedge clk_i);
    `CHK(pcnt, exp_p)
    cond_i[1:0] <= 2'b00;
    pin_set(2, 1'b1);
    pin_set(2, 1'b0);
    pin_set(2, 1'b1);
    exp_p++;
    `CHK(pcnt, exp_p)
    chk_rd(`CFI_A_FLAG, 32'h0000_0004);
    pin_set(2, 1'b0);
    `CHK(reduced_current_o, 1'b0)
    pin_set(2, 1'b1);
    exp_p++;
    `CHK(pcnt, exp_p)
    `CHK(reduced_current_o, 1'b1)
    cond_i[3] <= 1'b1;
    @(posedge clk_i);
    cond_i[4] <= 1'b1;
    repeat (40) @(posedge clk_i);
    exp_p = exp_p + 8'h02;
    `CHK(pcnt, exp_p)
    cond_i[4:2] <= 3'b000;
    `CHK(irq_o, 1'b1)
    wb(1'b1, `CFI_A_IRQ_MASK, 32'h0000_0007);
    settle();
    `CHK(irq_o, 1'b0)
    wb(1'b1, `CFI_A_IRQ_MASK, 32'h0000_0000);
    settle();
    `CHK(irq_o, 1'b1)
    wb(1'b1, `CFI_A_IRQ_STAT, 32'h0000_0007);
    settle();
    `CHK(irq_o, 1'b0)
    chk_rd(`CFI_A_IRQ_STAT, 32'h0000_0000);
    pin_set(6, 1'b1);
    exp_p++;
    `CHK(pcnt, exp_p)
    `CHK(charge_enable_o, 1'b1)
    `CHK(rail_from_input_o, 1'b1)
    pin_set(10, 1'b1);
    exp_p++;
    `CHK(pcnt, exp_p)
    `CHK(safety_timer_pause_o, 1'b1)
    `CHK(charge_enable_o, 1'b0)
    pin_set(10, 1'b0);
    pin_set(11, 1'b1);
    exp_p++;
    `CHK(pcnt, exp_p)
    `CHK(reduced_current_o, 1'b1)
    `CHK(safety_timer_double_o, 1'b0)
    wb(1'b1, `CFI_A_CTRL, 32'h0000_000C);
    settle();
    `CHK(safety_timer_double_o, 1'b1)
    `CHK(charge_enable_o, 1'b1)
    pin_set(11, 1'b0);
    wb(1'b1, `CFI_A_CTRL, 32'h0000_000B);
    settle();
    `CHK(rail_pulldown_o, 1'b1)
    `CHK(rail_from_input_o, 1'b0)
    wb(1'b1, `CFI_A_CTRL, 32'h0000_0008);
    pin_set(7, 1'b1);
    exp_p++;
    `CHK(pcnt, exp_p)
    `CHK(charge_enable_o, 1'b0)
    `CHK(rail_from_battery_o, 1'b1)
    pin_set(7, 1'b0);
    n0 = n_trst;
    pin_set(1, 1'b1);
    exp_p++;
    `CHK(pcnt, exp_p)
    `CHK(charge_enable_o, 1'b0)
    `CHK(n_trst, n0 + 1)
    recharge_threshold_i <= 1'b1;
    settle();
    `CHK(charge_enable_o, 1'b1)
    recharge_threshold_i <= 1'b0;
    pin_set(1, 1'b0);
    pin_set(6, 1'b0);
    `CHK(pcnt, exp_p)
    `CHK(charge_enable_o, 1'b0)
    `CHK(rail_from_battery_o, 1'b1)
    pin_set(8, 1'b1);
    exp_p++;
    `CHK(pcnt, exp_p)
    `CHK(battery_disconnect_o, 1'b1)
    `CHK(rail_from_battery_o, 1'b0)
    pin_set(8, 1'b0);
    rst_i <= 1'b1;
    startup_fault_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    pin_set(0, 1'b1);
    `CHK(pcnt, exp_p)
    chk_rd(`CFI_A_FLAG, 32'h0000_0000);
    chk_rd(`CFI_A_IRQ_STAT, 32'h0000_0002);
    close_out();
  end
endmodule : charger_fault_interrupt_unit_bench
